// File: hw/rtc_defines.vh
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH
// ==========================================================
// Register addresses
`define RTC_A_DATA_RATE_LOW 10'h10C
`define RTC_A_RATE_DEV_SHARED 10'h10D
`define RTC_A_DEVIATION_LOW 10'h10E
`define RTC_A_PA_SETUP 10'h114
`define RTC_A_MOD_IF_BANDWIDTH_SELECT_SETUP 10'h115
`define RTC_A_IMAGE_PHASE 10'h118
`define RTC_A_IMAGE_AMPL 10'h119
`define RTC_A_OPER_OPTIONS 10'h11A
`define RTC_A_FINE_COARSE_A 10'h307
`define RTC_A_SYNTH_CAL_CTRL 10'h338
`define RTC_A_VCO_BAND_OVR 10'h3CB
`define RTC_A_VCO_AMPL_OVR 10'h3CC
`define RTC_A_VCO_OVR_EN 10'h3CD
`define RTC_A_VCO_CAL_SETUP 10'h3D0
`define RTC_A_OSC_SETUP 10'h3D2
`define RTC_A_VCO_BAND_RES 10'h3DA
`define RTC_A_VCO_AMPL_RES 10'h3DB
// ==========================================================
// Field positions
`define RTC_PA_SEL_BIT 7
`define RTC_RATE_B_LSB 4
`define RTC_MOD_LSB 0
`define RTC_IF_BANDWIDTH_SELECT_LSB 6
`define RTC_BASEBAND_CAL_ENABLE_BIT 0
`define RTC_SYNTH_CAL_BIT 0
`define RTC_XTAL_DAC_LSB 0
// ==========================================================
// Field codes and values
`define RTC_MOD_GFSK 2'h2
`define RTC_MOD_GMSK 2'h3
`define RTC_IF_BANDWIDTH_SELECT_300 2'h3
`define RTC_OVR_EN_BYPASS 8'h03
`define RTC_CAL_CFG_BYPASS 8'h0F
`define RTC_XTAL_DAC_MAX 3'h4
`define RTC_FINE_MIN 6'h02
`define RTC_FINE_MAX 6'h3F
`define RTC_RST_FINE 8'h3F
`define RTC_RST_CAL_CTRL 8'h01
`define RTC_RST_IMG_AMPL 8'h07
`define RTC_RST_IMG_PHASE 8'h16
// ==========================================================
// Timing
`define RTC_CLK_MHZ 100
`define RTC_VCO_CAL_US 142
`define RTC_BASEBAND_CAL_ENABLE_US 100
`define RTC_VCO_CAL_CYC (`RTC_VCO_CAL_US * `RTC_CLK_MHZ)
`define RTC_BASEBAND_CAL_ENABLE_CYC (`RTC_BASEBAND_CAL_ENABLE_US * `RTC_CLK_MHZ)
`endif

// File: hw/rtc_radio_config.v
`timescale 1ns/1ns
`include "rtc_defines.vh"
module rtc_radio_config (
  input wire core_clk,
  input wire rst_b,
  input wire memWrite,
  input wire memRead,
  input wire [9:0] memAddr,
  input wire [7:0] memWrData,
  output reg [7:0] memRdData,
  input wire enterTransmitCommand,
  input wire enterReceiveCommand,
  input wire enterIdleOnCommand,
  input wire [7:0] vcoBandMeasured,
  input wire [7:0] vcoAmplitudeMeasured,
  output reg transmitState,
  output reg receiveState,
  output reg idleOnState,
  output reg vcoCalBusy,
  output reg bbCalBusy,
  output reg [7:0] vcoBandApplied,
  output reg [7:0] vcoAmplitudeApplied,
  output reg [2:0] crystalPullingCode,
  output reg [3:0] crystalPullQuarterPpm,
  output reg [1:0] modulationMode,
  output reg gaussianEnable,
  output reg [11:0] deviationValue,
  output reg [11:0] dataRateValue,
  output reg [1:0] ifBandwidthSelect,
  output reg ifCentre300,
  output reg singlePaEnable,
  output reg diffPaEnable,
  output reg [5:0] paLevelNow
);

  // ==========================================================
  // State codes
  localparam ST_IDLE = 3'h0;
  localparam ST_BBCAL = 3'h1;
  localparam ST_ON = 3'h2;
  localparam ST_VCOCAL = 3'h3;
  localparam ST_TX = 3'h4;
  localparam ST_RX = 3'h5;
  // Timer loads; the part-selects below cut them to the 15-bit timer on purpose
  localparam [31:0] BASEBAND_CAL_ENABLE_LOAD = `RTC_BASEBAND_CAL_ENABLE_CYC - 1;
  localparam [31:0] VCO_CAL_LOAD = `RTC_VCO_CAL_CYC - 1;

  // Coarse to fine Coarse_a mapping, shared by ramp target logic
  function [5:0] coarseToFine;
    input [3:0] coarse;
    begin
      coarseToFine = {coarse, 2'b11};
    end
  endfunction

  // Clamp a fine level into its legal span
  function [5:0] clampFine;
    input [5:0] lvl;
    begin
      if (lvl < `RTC_FINE_MIN)
        clampFine = `RTC_FINE_MIN;
      else
        clampFine = lvl;
    end
  endfunction

  // ==========================================================
  // Register storage
  reg [7:0] dataRateLow_r;
  reg [7:0] rateDevShared_r;
  reg [7:0] deviationLow_r;
  reg [7:0] paSetup_r;
  reg [7:0] modIfbwSetup_r;
  reg [7:0] imagePhase_r;
  reg [7:0] imageAmpl_r;
  reg [7:0] operOptions_r;
  reg [7:0] finePaLevel_r;
  reg [7:0] synthCalCtrl_r;
  reg [7:0] vcoBandOvr_r;
  reg [7:0] vcoAmplOvr_r;
  reg [7:0] vcoOvrEn_r;
  reg [7:0] vcoCalSetup_r;
  reg [7:0] oscSetup_r;
  reg [7:0] vcoBandRes_r;
  reg [7:0] vcoAmplRes_r;
  reg fineSelected_r;
  reg calArmed_r;
  reg [2:0] state_r;
  reg [2:0] pendState_r;
  reg [14:0] calCnt_r;

  wire bypassSet;
  wire paWanted;
  wire [5:0] targetLevel;
  wire [5:0] rampStep;
  wire bitTick;
  reg [11:0] bitCnt_r;

  // Bypass only counts when both override registers hold their magic values
  assign bypassSet = (vcoOvrEn_r == `RTC_OVR_EN_BYPASS) &&
    (vcoCalSetup_r == `RTC_CAL_CFG_BYPASS) && calArmed_r;
  assign paWanted = (state_r == ST_TX);
  // The latest written of coarse or fine level steers the target
  assign targetLevel = fineSelected_r ? clampFine(finePaLevel_r[5:0]) :
    coarseToFine(paSetup_r[3:0]);
  // Ramp step doubles per setting, 1..32 codes per bit; 64 and up saturate at 63
  assign rampStep = (paSetup_r[6:4] >= 3'h6) ? 6'h3F :
    ({5'h00, 1'b1} << paSetup_r[6:4]);

  // ==========================================================
  // Register writes; a cal-enable 0 then 1 sequence arms bypass
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dataRateLow_r <= 8'h00;
      rateDevShared_r <= 8'h00;
      deviationLow_r <= 8'h00;
      paSetup_r <= 8'h00;
      modIfbwSetup_r <= 8'h00;
      imagePhase_r <= `RTC_RST_IMG_PHASE;
      imageAmpl_r <= `RTC_RST_IMG_AMPL;
      operOptions_r <= 8'h00;
      finePaLevel_r <= `RTC_RST_FINE;
      synthCalCtrl_r <= `RTC_RST_CAL_CTRL;
      vcoBandOvr_r <= 8'h00;
      vcoAmplOvr_r <= 8'h00;
      vcoOvrEn_r <= 8'h00;
      vcoCalSetup_r <= 8'h00;
      oscSetup_r <= {5'h00, `RTC_XTAL_DAC_MAX};
      fineSelected_r <= 1'b0;
      calArmed_r <= 1'b0;
    end
    else if (memWrite)
    begin
      case (memAddr)
        `RTC_A_DATA_RATE_LOW: dataRateLow_r <= memWrData;
        `RTC_A_RATE_DEV_SHARED: rateDevShared_r <= memWrData;
        `RTC_A_DEVIATION_LOW: deviationLow_r <= memWrData;
        `RTC_A_PA_SETUP:
        begin
          paSetup_r <= memWrData;
          fineSelected_r <= 1'b0;
        end
        `RTC_A_MOD_IF_BANDWIDTH_SELECT_SETUP: modIfbwSetup_r <= memWrData;
        `RTC_A_IMAGE_PHASE: imagePhase_r <= memWrData;
        `RTC_A_IMAGE_AMPL: imageAmpl_r <= memWrData;
        `RTC_A_OPER_OPTIONS: operOptions_r <= memWrData;
        `RTC_A_FINE_COARSE_A:
        begin
          finePaLevel_r <= {2'b00, memWrData[5:0]};
          fineSelected_r <= 1'b1;
        end
        `RTC_A_SYNTH_CAL_CTRL:
        begin
          synthCalCtrl_r <= memWrData;
          // Rising edge of the enable bit arms the bypass
          calArmed_r <= memWrData[`RTC_SYNTH_CAL_BIT] &&
            !synthCalCtrl_r[`RTC_SYNTH_CAL_BIT];
        end
        `RTC_A_VCO_BAND_OVR: vcoBandOvr_r <= memWrData;
        `RTC_A_VCO_AMPL_OVR: vcoAmplOvr_r <= memWrData;
        `RTC_A_VCO_OVR_EN: vcoOvrEn_r <= memWrData;
        `RTC_A_VCO_CAL_SETUP: vcoCalSetup_r <= memWrData;
        `RTC_A_OSC_SETUP: oscSetup_r <= {5'h00, memWrData[2:0]};
        default: ;
      endcase
    end
    else if ((enterTransmitCommand || enterReceiveCommand) && state_r == ST_ON)
      calArmed_r <= 1'b0; // Bypass is consumed by one command; a register write in the same cycle takes priority over it
  end

  // ==========================================================
  // Read mux; unmapped and results read as shown
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      memRdData <= 8'h00;
    else if (memRead)
    begin
      case (memAddr)
        `RTC_A_DATA_RATE_LOW: memRdData <= dataRateLow_r;
        `RTC_A_RATE_DEV_SHARED: memRdData <= rateDevShared_r;
        `RTC_A_DEVIATION_LOW: memRdData <= deviationLow_r;
        `RTC_A_PA_SETUP: memRdData <= paSetup_r;
        `RTC_A_MOD_IF_BANDWIDTH_SELECT_SETUP: memRdData <= modIfbwSetup_r;
        `RTC_A_IMAGE_PHASE: memRdData <= imagePhase_r;
        `RTC_A_IMAGE_AMPL: memRdData <= imageAmpl_r;
        `RTC_A_OPER_OPTIONS: memRdData <= operOptions_r;
        `RTC_A_FINE_COARSE_A: memRdData <= finePaLevel_r;
        `RTC_A_SYNTH_CAL_CTRL: memRdData <= synthCalCtrl_r;
        `RTC_A_VCO_BAND_OVR: memRdData <= vcoBandOvr_r;
        `RTC_A_VCO_AMPL_OVR: memRdData <= vcoAmplOvr_r;
        `RTC_A_VCO_OVR_EN: memRdData <= vcoOvrEn_r;
        `RTC_A_VCO_CAL_SETUP: memRdData <= vcoCalSetup_r;
        `RTC_A_OSC_SETUP: memRdData <= oscSetup_r;
        `RTC_A_VCO_BAND_RES: memRdData <= vcoBandRes_r;
        `RTC_A_VCO_AMPL_RES: memRdData <= vcoAmplRes_r;
        default: memRdData <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Radio state sequencer with VCO and filter calibration timers
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ST_IDLE;
      pendState_r <= ST_TX;
      calCnt_r <= 15'h0000;
      vcoBandRes_r <= 8'h00;
      vcoAmplRes_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        // Idle-on entry from any settled state reruns the filter calibration when enabled
        ST_IDLE, ST_TX, ST_RX:
          if (enterIdleOnCommand)
          begin
            state_r <= operOptions_r[`RTC_BASEBAND_CAL_ENABLE_BIT] ? ST_BBCAL : ST_ON;
            calCnt_r <= BASEBAND_CAL_ENABLE_LOAD[14:0];
          end
        ST_BBCAL:
          if (calCnt_r == 15'h0000)
            state_r <= ST_ON;
          else
            calCnt_r <= calCnt_r - 15'h0001;
        ST_ON:
          if (enterTransmitCommand || enterReceiveCommand)
          begin
            pendState_r <= enterTransmitCommand ? ST_TX : ST_RX;
            if (bypassSet)
            begin
              state_r <= enterTransmitCommand ? ST_TX : ST_RX;
              vcoBandRes_r <= vcoBandOvr_r;
              vcoAmplRes_r <= vcoAmplOvr_r;
            end
            else
            begin
              state_r <= ST_VCOCAL;
              calCnt_r <= VCO_CAL_LOAD[14:0];
            end
          end
        ST_VCOCAL:
          if (calCnt_r == 15'h0000)
          begin
            state_r <= pendState_r;
            vcoBandRes_r <= vcoBandMeasured;
            vcoAmplRes_r <= vcoAmplitudeMeasured;
          end
          else
            calCnt_r <= calCnt_r - 15'h0001;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Bit period tick from the data-rate field (100 Hz units)
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      bitCnt_r <= 12'h000;
    else if (bitTick)
      bitCnt_r <= 12'h000;
    else
      bitCnt_r <= bitCnt_r + 12'h001;
  end
  // Coarse approximation: one ramp step each time the counter meets the rate code
  assign bitTick = (bitCnt_r >= dataRateValue);

  // ==========================================================
  // Rate_b: steps to target while transmitting, falls to zero otherwise
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      paLevelNow <= 6'h00;
    else if (bitTick)
    begin
      // While transmitting, down steps stop at the target so the level never dips below it
      if (paWanted && paLevelNow < targetLevel)
        paLevelNow <= (targetLevel - paLevelNow > rampStep) ?
          paLevelNow + rampStep : targetLevel;
      else if (paWanted && paLevelNow > targetLevel)
        paLevelNow <= (paLevelNow - targetLevel > rampStep) ?
          paLevelNow - rampStep : targetLevel;
      else if (!paWanted)
        paLevelNow <= (paLevelNow > rampStep) ? paLevelNow - rampStep : 6'h00;
    end
  end

  // ==========================================================
  // Registered decode of configuration outputs
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      transmitState <= 1'b0;
      receiveState <= 1'b0;
      idleOnState <= 1'b0;
      vcoCalBusy <= 1'b0;
      bbCalBusy <= 1'b0;
      vcoBandApplied <= 8'h00;
      vcoAmplitudeApplied <= 8'h00;
      crystalPullingCode <= `RTC_XTAL_DAC_MAX;
      crystalPullQuarterPpm <= 4'h0;
      modulationMode <= 2'h0;
      gaussianEnable <= 1'b0;
      deviationValue <= 12'h000;
      dataRateValue <= 12'h000;
      ifBandwidthSelect <= 2'h0;
      ifCentre300 <= 1'b0;
      singlePaEnable <= 1'b0;
      diffPaEnable <= 1'b0;
    end
    else
    begin
      transmitState <= (state_r == ST_TX);
      receiveState <= (state_r == ST_RX);
      idleOnState <= (state_r == ST_ON);
      vcoCalBusy <= (state_r == ST_VCOCAL);
      bbCalBusy <= (state_r == ST_BBCAL);
      vcoBandApplied <= vcoBandRes_r;
      vcoAmplitudeApplied <= vcoAmplRes_r;
      crystalPullingCode <= oscSetup_r[2:0];
      // Pull in quarter-ppm units: code 0 -> 4 (1 ppm), code 4 -> 0
      crystalPullQuarterPpm <= (oscSetup_r[2:0] > `RTC_XTAL_DAC_MAX) ? 4'h0 :
        (4'h4 - {1'b0, oscSetup_r[2:0]});
      modulationMode <= modIfbwSetup_r[1:0];
      gaussianEnable <= (modIfbwSetup_r[1:0] == `RTC_MOD_GFSK) ||
        (modIfbwSetup_r[1:0] == `RTC_MOD_GMSK);
      deviationValue <= {rateDevShared_r[7:4], deviationLow_r};
      dataRateValue <= {rateDevShared_r[3:0], dataRateLow_r};
      ifBandwidthSelect <= modIfbwSetup_r[7:6];
      ifCentre300 <= (modIfbwSetup_r[7:6] == `RTC_IF_BANDWIDTH_SELECT_300);
      // Mutually exclusive by construction of the select bit
      singlePaEnable <= paWanted && !paSetup_r[`RTC_PA_SEL_BIT];
      diffPaEnable <= paWanted && paSetup_r[`RTC_PA_SEL_BIT];
    end
  end

endmodule // rtc_radio_config

// File: test/rtc_radio_config_assertions.sv
`timescale 1ns/1ns
// ==========================================
// Port checks of the radio configuration block
module rtc_radio_config_assertions (
  input wire core_clk,
  input wire rst_b,
  input wire memWrite,
  input wire [1:0] modulationMode,
  input wire gaussianEnable,
  input wire [11:0] deviationValue,
  input wire [11:0] dataRateValue,
  input wire [1:0] ifBandwidthSelect,
  input wire ifCentre300,
  input wire [2:0] crystalPullingCode,
  input wire [3:0] crystalPullQuarterPpm,
  input wire singlePaEnable,
  input wire diffPaEnable,
  input wire idleOnState,
  input wire enterTransmitCommand,
  input wire vcoCalBusy,
  input wire bbCalBusy,
  input wire transmitState
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  reg [15:0] vcoCnt_r;
  reg [15:0] bbCnt_r;
  // Busy run lengths; a counter avoids unrolling thousands of cycles
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vcoCnt_r <= 16'h0000;
      bbCnt_r <= 16'h0000;
    end
    else
    begin
      vcoCnt_r <= vcoCalBusy ? vcoCnt_r + 16'h0001 : 16'h0000;
      bbCnt_r <= bbCalBusy ? bbCnt_r + 16'h0001 : 16'h0000;
    end
  end
  AST_PA_EXCL: assert property (!(singlePaEnable && diffPaEnable))
    else $error("both amplifiers enabled");
  AST_GAUSS: assert property ($stable(modulationMode) |->
    gaussianEnable == modulationMode[1])
    else $error("gaussian shaping does not follow modulation");
  AST_CENTRE: assert property ($stable(ifBandwidthSelect) |->
    ifCentre300 == (ifBandwidthSelect == 2'h3)) else $error("wrong IF centre");
  AST_PULL: assert property ($stable(crystalPullingCode) &&
    crystalPullingCode <= 3'h4 |-> crystalPullQuarterPpm == 4'h4 - {1'b0, crystalPullingCode})
    else $error("wrong pull");
  AST_VCO_LEN: assert property ($fell(vcoCalBusy) |->
    vcoCnt_r >= 16'h3777 && vcoCnt_r <= 16'h3779)
    else $error("VCO calibration length wrong");
  AST_BB_LEN: assert property ($fell(bbCalBusy) |->
    bbCnt_r >= 16'h270F && bbCnt_r <= 16'h2711)
    else $error("filter calibration length wrong");
  AST_TX_CMD: assert property (enterTransmitCommand && idleOnState &&
    !vcoCalBusy && !bbCalBusy |-> ##[1:2] (vcoCalBusy || transmitState))
    else $error("transmit command not taken");
  AST_DEV_HOLD: assert property (!memWrite && !$past(memWrite) |=>
    $stable(deviationValue)) else $error("deviation changed without a write");
  AST_RATE_HOLD: assert property (!memWrite && !$past(memWrite) |=>
    $stable(dataRateValue)) else $error("data rate changed without a write");
  // Main scenarios reached
  cover property ($fell(vcoCalBusy));
  cover property ($fell(bbCalBusy));
  cover property ($rose(diffPaEnable));
  cover property ($rose(gaussianEnable));
endmodule // rtc_radio_config_assertions

bind rtc_radio_config rtc_radio_config_assertions rtc_radio_config_assertions_i (
  .core_clk(core_clk), .rst_b(rst_b), .memWrite(memWrite), .modulationMode(modulationMode),
  .gaussianEnable(gaussianEnable), .deviationValue(deviationValue),
  .dataRateValue(dataRateValue), .ifBandwidthSelect(ifBandwidthSelect),
  .ifCentre300(ifCentre300), .crystalPullingCode(crystalPullingCode),
  .crystalPullQuarterPpm(crystalPullQuarterPpm), .singlePaEnable(singlePaEnable),
  .diffPaEnable(diffPaEnable), .idleOnState(idleOnState),
  .enterTransmitCommand(enterTransmitCommand), .vcoCalBusy(vcoCalBusy),
  .bbCalBusy(bbCalBusy), .transmitState(transmitState));

// File: test/rtc_host_model.sv
`timescale 1ns/1ns
// ==========================================
// Host processor on the register bus
module rtc_host_model (
  input wire core_clk,
  output reg memWrite,
  output reg memRead,
  output reg [9:0] memAddr,
  output reg [7:0] memWrData,
  input wire [7:0] memRdData
);
  // Image calibration is never started, so no firmware download is needed
  initial
  begin
    memWrite = 1'b0;
    memRead = 1'b0;
    memAddr = 10'h000;
    memWrData = 8'h00;
  end
  // Idle bus shows inverted values so stale data never looks valid
  task wr(input [9:0] a, input [7:0] d);
  begin
    @(posedge core_clk);
    memWrite <= 1'b1;
    memAddr <= a;
    memWrData <= d;
    @(posedge core_clk);
    memWrite <= 1'b0;
    memAddr <= ~a;
    memWrData <= ~d;
  end
  endtask
  // Read data is taken one cycle after the strobe
  task rd(input [9:0] a, output [7:0] d);
  begin
    @(posedge core_clk);
    memRead <= 1'b1;
    memAddr <= a;
    @(posedge core_clk);
    memRead <= 1'b0;
    memAddr <= ~a;
    @(posedge core_clk);
    d = memRdData;
  end
  endtask
  // Each write completes before the next; the order matters to the arming logic
  task bypass(input [7:0] band, input [7:0] ampl);
  begin
    wr(10'h3CD, 8'h03);
    wr(10'h3D0, 8'h0F);
    wr(10'h3CB, band);
    wr(10'h3CC, ampl);
    wr(10'h338, 8'h00);
    wr(10'h338, 8'h01);
  end
  endtask
endmodule // rtc_host_model

// File: test/rtc_radio_config_tb.sv
`timescale 1ns/1ns
module rtc_radio_config_tb;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg enterTransmitCommand = 1'b0;
  reg enterReceiveCommand = 1'b0;
  reg enterIdleOnCommand = 1'b0;
  reg [7:0] vcoBandMeasured = 8'h11;
  reg [7:0] vcoAmplitudeMeasured = 8'h22;
  wire memWrite, memRead, transmitState, receiveState, idleOnState, vcoCalBusy, bbCalBusy;
  wire gaussianEnable, ifCentre300, singlePaEnable, diffPaEnable;
  wire [9:0] memAddr;
  wire [7:0] memWrData, memRdData, vcoBandApplied, vcoAmplitudeApplied;
  wire [2:0] crystalPullingCode;
  wire [3:0] crystalPullQuarterPpm;
  wire [1:0] modulationMode, ifBandwidthSelect;
  wire [11:0] deviationValue, dataRateValue;
  wire [5:0] paLevelNow;
  integer numErrors = 0;
  integer checks = 0;
  integer cycles = 0;
  integer i;
  reg [7:0] rb;
  reg [7:0] band;
  reg [7:0] ampl;
  // ==========================================
  // Clock, timeout and instances
  always #5 core_clk = ~core_clk;
  // Runs need about 24400 cycles; anything far beyond is a hang
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      numErrors = numErrors + 1;
      giveVerdict;
    end
  end
  rtc_host_model rtc_host_model_i (.core_clk(core_clk), .memWrite(memWrite), .memRead(memRead),
    .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData));
  rtc_radio_config rtc_radio_config_i (.core_clk(core_clk), .rst_b(rst_b),
    .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr), .memWrData(memWrData),
    .memRdData(memRdData), .enterTransmitCommand(enterTransmitCommand),
    .enterReceiveCommand(enterReceiveCommand), .enterIdleOnCommand(enterIdleOnCommand),
    .vcoBandMeasured(vcoBandMeasured), .vcoAmplitudeMeasured(vcoAmplitudeMeasured),
    .transmitState(transmitState), .receiveState(receiveState), .idleOnState(idleOnState),
    .vcoCalBusy(vcoCalBusy), .bbCalBusy(bbCalBusy), .vcoBandApplied(vcoBandApplied),
    .vcoAmplitudeApplied(vcoAmplitudeApplied), .crystalPullingCode(crystalPullingCode),
    .crystalPullQuarterPpm(crystalPullQuarterPpm), .modulationMode(modulationMode),
    .gaussianEnable(gaussianEnable), .deviationValue(deviationValue),
    .dataRateValue(dataRateValue), .ifBandwidthSelect(ifBandwidthSelect),
    .ifCentre300(ifCentre300), .singlePaEnable(singlePaEnable), .diffPaEnable(diffPaEnable),
    .paLevelNow(paLevelNow));
  // ==========================================
  // Shared tasks
  task chk(input [8*10:1] what, input [11:0] exp, input [11:0] got);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      numErrors = numErrors + 1;
      $display("BAD %0s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task rc(input [9:0] a, input [7:0] e);
  begin
    rtc_host_model_i.rd(a, rb);
    chk("readback", {4'h0, e}, {4'h0, rb});
  end
  endtask
  // Command pulse one cycle wide: 0 transmit, 1 receive, 2 idle-on
  task pulse(input [1:0] k);
  begin
    @(posedge core_clk);
    enterTransmitCommand <= (k == 2'h0);
    enterReceiveCommand <= (k == 2'h1);
    enterIdleOnCommand <= (k == 2'h2);
    @(posedge core_clk);
    enterTransmitCommand <= 1'b0;
    enterReceiveCommand <= 1'b0;
    enterIdleOnCommand <= 1'b0;
  end
  endtask
  task go_idle;
  begin
    pulse(2'h2);
    for (i = 0; i < 20 && idleOnState !== 1'b1; i = i + 1) @(posedge core_clk);
  end
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
  begin
    chk("xtalcode", 12'h004, {9'h000, crystalPullingCode});
    rc(10'h118, 8'h16);
    rc(10'h119, 8'h07);
    rc(10'h307, 8'h3F);
    rc(10'h3D2, 8'h04);
    rc(10'h000, 8'h00);
    rtc_host_model_i.wr(10'h3DA, 8'hFF);
    rc(10'h3DA, 8'h00);
    rtc_host_model_i.wr(10'h119, 8'h07);
    rtc_host_model_i.wr(10'h118, 8'h16);
    $display("test reset done");
  end
  endtask
  task t_fields;
  begin
    rtc_host_model_i.wr(10'h10C, 8'h0A);
    rtc_host_model_i.wr(10'h10D, 8'h50);
    rtc_host_model_i.wr(10'h10E, 8'h12);
    repeat (2) @(posedge core_clk);
    chk("rate", 12'h00A, dataRateValue);
    chk("deviation", 12'h512, deviationValue);
    for (i = 0; i < 4; i = i + 1)
    begin
      rtc_host_model_i.wr(10'h115, {i[1:0], 4'h0, i[1:0]});
      repeat (2) @(posedge core_clk);
      chk("modulation", i, {10'h000, modulationMode});
      chk("gaussian", {11'h000, i[1]}, {11'h000, gaussianEnable});
      chk("if_bandwidth_select", i, {10'h000, ifBandwidthSelect});
      chk("centre300", {11'h000, i == 3}, {11'h000, ifCentre300});
    end
    for (i = 0; i < 5; i = i + 1)
    begin
      rtc_host_model_i.wr(10'h3D2, i[7:0]);
      repeat (2) @(posedge core_clk);
      chk("xtalcode", i, {9'h000, crystalPullingCode});
      chk("pullppm", 4 - i, {8'h00, crystalPullQuarterPpm});
    end
    $display("test fields done");
  end
  endtask
  task t_cal_rx;
  begin
    go_idle;
    pulse(2'h1);
    repeat (2) @(posedge core_clk);
    chk("vcobusy", 12'h001, {11'h000, vcoCalBusy});
    for (i = 0; i < 14400 && receiveState !== 1'b1; i = i + 1) @(posedge core_clk);
    chk("rxstate", 12'h001, {11'h000, receiveState});
    chk("singlepa", 12'h000, {11'h000, singlePaEnable});
    rtc_host_model_i.rd(10'h3DA, band);
    rtc_host_model_i.rd(10'h3DB, ampl);
    chk("band", 12'h011, {4'h0, band});
    chk("ampl", 12'h022, {4'h0, ampl});
    $display("test calibrated receive done");
  end
  endtask
  task t_bypass;
  begin
    vcoBandMeasured <= 8'h33;
    vcoAmplitudeMeasured <= 8'h44;
    go_idle;
    rtc_host_model_i.wr(10'h114, 8'hF5);
    rtc_host_model_i.bypass(band, ampl);
    pulse(2'h0);
    repeat (3) @(posedge core_clk);
    chk("txstate", 12'h001, {11'h000, transmitState});
    chk("vcobusy", 12'h000, {11'h000, vcoCalBusy});
    chk("bandapply", 12'h011, {4'h0, vcoBandApplied});
    chk("amplapply", 12'h022, {4'h0, vcoAmplitudeApplied});
    for (i = 0; i < 500 && paLevelNow !== 6'h17; i = i + 1) @(posedge core_clk);
    chk("palevel", 12'h017, {6'h00, paLevelNow});
    chk("diffpa", 12'h001, {11'h000, diffPaEnable});
    chk("singlepa", 12'h000, {11'h000, singlePaEnable});
    rtc_host_model_i.wr(10'h307, 8'h01);
    for (i = 0; i < 500 && paLevelNow !== 6'h02; i = i + 1) @(posedge core_clk);
    chk("palevel", 12'h002, {6'h00, paLevelNow});
    // Coarse write takes over again and switches to the single-ended amplifier
    rtc_host_model_i.wr(10'h114, 8'h75);
    for (i = 0; i < 500 && paLevelNow !== 6'h17; i = i + 1) @(posedge core_clk);
    chk("palevel", 12'h017, {6'h00, paLevelNow});
    chk("singlepa", 12'h001, {11'h000, singlePaEnable});
    chk("diffpa", 12'h000, {11'h000, diffPaEnable});
    $display("test bypass transmit done");
  end
  endtask
  task t_bbcal;
  begin
    rtc_host_model_i.wr(10'h11A, 8'h01);
    pulse(2'h2);
    repeat (3) @(posedge core_clk);
    chk("bbbusy", 12'h001, {11'h000, bbCalBusy});
    repeat (9900) @(posedge core_clk);
    chk("bbbusy", 12'h001, {11'h000, bbCalBusy});
    for (i = 0; i < 300 && idleOnState !== 1'b1; i = i + 1) @(posedge core_clk);
    chk("idleon", 12'h001, {11'h000, idleOnState});
    chk("singlepa", 12'h000, {11'h000, singlePaEnable});
    $display("test filter calibration done");
  end
  endtask
  task giveVerdict;
  begin
    $display("checks %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset;
    t_fields;
    t_cal_rx;
    t_bypass;
    t_bbcal;
    giveVerdict;
  end
endmodule // rtc_radio_config_tb
